// >>> hw/epm_counters.v
// clear-on-read error and slip counters of the e1 performance monitor with an apb slave
`timescale 1ns/1ps
`include "epm_defs.vh"

module epm_counters
(
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`EPM_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	input wire pattern_error_evt,
	input wire tx_slip_evt,
	input wire zero_violation_evt,
	output wire irq
);

	// saturating increment of a 16-bit count
	function [15:0] sat_inc16;
		input [15:0] cnt;
		input ev;
		begin
			if (ev && (cnt != 16'hFFFF))
				sat_inc16 = cnt + 16'h0001;
			else
				sat_inc16 = cnt;
		end
	endfunction

	// saturating increment of an 8-bit count
	function [7:0] sat_inc8;
		input [7:0] cnt;
		input ev;
		begin
			if (ev && (cnt != 8'hFF))
				sat_inc8 = cnt + 8'h01;
			else
				sat_inc8 = cnt;
		end
	endfunction

	// true when this cycle takes a 16-bit count to all ones; only the transition raises a flag
	function reached16;
		input [15:0] nxt;
		input [15:0] cur;
		begin
			reached16 = (nxt == 16'hFFFF) && (cur != 16'hFFFF);
		end
	endfunction

	// true when this cycle takes an 8-bit count to all ones
	function reached8;
		input [7:0] nxt;
		input [7:0] cur;
		begin
			reached8 = (nxt == 8'hFF) && (cur != 8'hFF);
		end
	endfunction

	reg [15:0] pat_cnt_q;
	reg [15:0] pat_cnt_d;
	reg [15:0] pat_hold_q;
	reg [15:0] pat_hold_d;
	reg pat_pend_q;
	reg pat_pend_d;
	reg [15:0] zv_cnt_q;
	reg [15:0] zv_cnt_d;
	reg [15:0] zv_hold_q;
	reg [15:0] zv_hold_d;
	reg zv_pend_q;
	reg zv_pend_d;
	reg [7:0] slip_cnt_q;
	reg [7:0] slip_cnt_d;
	reg [15:0] lat_q;
	reg [15:0] lat_d;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg err_q;
	reg err_d;
	reg [`EPM_IRQ_W-1:0] irq_stat_q;
	reg [`EPM_IRQ_W-1:0] irq_stat_d;
	reg [`EPM_IRQ_W-1:0] irq_mask_q;
	reg [`EPM_IRQ_W-1:0] irq_mask_d;
	reg [`EPM_IRQ_W-1:0] sat_set;
	reg [`EPM_IRQ_W-1:0] w1c;

	wire setup_ph;
	wire access_ph;
	wire rd_acc;
	wire wr_acc;
	wire sel_pat_hi;
	wire sel_pat_lo;
	wire sel_slip;
	wire sel_zv_hi;
	wire sel_zv_lo;
	wire sel_stat;
	wire sel_mask;
	wire mapped;

	// slave never inserts wait states, but a frozen block must not finish a transfer
	assign pready = clk_en;
	assign prdata = rdata_q;
	assign pslverr = err_q & access_ph;
	assign irq = |(irq_stat_q & irq_mask_q);

	// phase and address decode
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign rd_acc = access_ph & ~pwrite & clk_en;
	assign wr_acc = access_ph & pwrite & clk_en;
	assign sel_pat_hi = (paddr == `EPM_OFF_PAT_UPPER);
	assign sel_pat_lo = (paddr == `EPM_OFF_PAT_LOWER);
	assign sel_slip = (paddr == `EPM_OFF_SLIP);
	assign sel_zv_hi = (paddr == `EPM_OFF_ZV_UPPER);
	assign sel_zv_lo = (paddr == `EPM_OFF_ZV_LOWER);
	assign sel_stat = (paddr == `EPM_OFF_IRQ_STATUS);
	assign sel_mask = (paddr == `EPM_OFF_IRQ_MASK);
	assign mapped = sel_pat_hi | sel_pat_lo | sel_slip | sel_zv_hi | sel_zv_lo
		| sel_stat | sel_mask;

	// read data and the full-width snapshot are taken in the setup cycle so that
	// prdata comes from a flop; the access edge then subtracts exactly what was shown
	always @*
	begin
		rdata_d = rdata_q;
		lat_d = lat_q;
		err_d = err_q;
		if (setup_ph)
		begin
			rdata_d = 32'h00000000;
			lat_d = 16'h0000;
			err_d = ~mapped;
			if (sel_pat_hi)
			begin
				rdata_d[7:0] = pat_cnt_q[`EPM_HI_MSB:`EPM_HI_LSB];
				lat_d = pat_cnt_q;
			end
			else if (sel_pat_lo)
			begin
				// a lower read after an upper read returns the captured byte
				if (pat_pend_q)
					rdata_d[7:0] = pat_hold_q[`EPM_LO_MSB:`EPM_LO_LSB];
				else
					rdata_d[7:0] = pat_cnt_q[`EPM_LO_MSB:`EPM_LO_LSB];
			end
			else if (sel_slip)
			begin
				rdata_d[7:0] = slip_cnt_q;
				lat_d = {8'h00, slip_cnt_q};
			end
			else if (sel_zv_hi)
			begin
				rdata_d[7:0] = zv_cnt_q[`EPM_HI_MSB:`EPM_HI_LSB];
				lat_d = zv_cnt_q;
			end
			else if (sel_zv_lo)
			begin
				if (zv_pend_q)
					rdata_d[7:0] = zv_hold_q[`EPM_LO_MSB:`EPM_LO_LSB];
				else
					rdata_d[7:0] = zv_cnt_q[`EPM_LO_MSB:`EPM_LO_LSB];
			end
			else if (sel_stat)
				rdata_d[`EPM_IRQ_W-1:0] = irq_stat_q;
			else if (sel_mask)
				rdata_d[`EPM_IRQ_W-1:0] = irq_mask_q;
		end
	end

	// pattern error counter with upper/lower read pairing
	always @*
	begin
		pat_cnt_d = sat_inc16(pat_cnt_q, pattern_error_evt);
		pat_hold_d = pat_hold_q;
		pat_pend_d = pat_pend_q;
		if (rd_acc && sel_pat_hi)
		begin
			// a repeated upper read simply takes a fresh snapshot
			pat_hold_d = lat_q;
			pat_pend_d = 1'b1;
		end
		else if (rd_acc && sel_pat_lo && pat_pend_q)
		begin
			// only the snapshot is removed, so events since the upper read survive
			pat_cnt_d = sat_inc16(pat_cnt_q - pat_hold_q, pattern_error_evt);
			pat_pend_d = 1'b0;
		end
	end

	// excessive-zero violation counter, same pairing as the pattern counter
	always @*
	begin
		zv_cnt_d = sat_inc16(zv_cnt_q, zero_violation_evt);
		zv_hold_d = zv_hold_q;
		zv_pend_d = zv_pend_q;
		if (rd_acc && sel_zv_hi)
		begin
			zv_hold_d = lat_q;
			zv_pend_d = 1'b1;
		end
		else if (rd_acc && sel_zv_lo && zv_pend_q)
		begin
			zv_cnt_d = sat_inc16(zv_cnt_q - zv_hold_q, zero_violation_evt);
			zv_pend_d = 1'b0;
		end
	end

	// transmit slip counter: one strobe per repeated or dropped frame
	always @*
	begin
		slip_cnt_d = sat_inc8(slip_cnt_q, tx_slip_evt);
		if (rd_acc && sel_slip)
			slip_cnt_d = sat_inc8(slip_cnt_q - lat_q[7:0], tx_slip_evt);
	end

	// write-one-to-clear strobes for the status bits
	always @*
	begin
		w1c = {`EPM_IRQ_W{1'b0}};
		if (wr_acc && sel_stat && pstrb[0])
			w1c = pwdata[`EPM_IRQ_W-1:0];
	end

	// sticky saturation flags; a set in the cycle of its clear wins
	always @*
	begin
		sat_set = {`EPM_IRQ_W{1'b0}};
		sat_set[`EPM_IRQ_PAT_SAT] = reached16(pat_cnt_d, pat_cnt_q);
		sat_set[`EPM_IRQ_ZV_SAT] = reached16(zv_cnt_d, zv_cnt_q);
		sat_set[`EPM_IRQ_SLIP_SAT] = reached8(slip_cnt_d, slip_cnt_q);
		irq_stat_d = (irq_stat_q & ~w1c) | sat_set;
	end

	// interrupt mask, plain read/write
	always @*
	begin
		irq_mask_d = irq_mask_q;
		if (wr_acc && sel_mask && pstrb[0])
			irq_mask_d = pwdata[`EPM_IRQ_W-1:0];
	end

	// pattern counter state; frozen with the clock enable so no strobe is half taken
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pat_cnt_q <= `EPM_RST_CNT16;
			pat_hold_q <= `EPM_RST_CNT16;
			pat_pend_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pat_cnt_q <= pat_cnt_d;
			pat_hold_q <= pat_hold_d;
			pat_pend_q <= pat_pend_d;
		end
	end

	// zero violation counter state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			zv_cnt_q <= `EPM_RST_CNT16;
			zv_hold_q <= `EPM_RST_CNT16;
			zv_pend_q <= 1'b0;
		end
		else if (clk_en)
		begin
			zv_cnt_q <= zv_cnt_d;
			zv_hold_q <= zv_hold_d;
			zv_pend_q <= zv_pend_d;
		end
	end

	// transmit slip counter state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slip_cnt_q <= `EPM_RST_CNT8;
		end
		else if (clk_en)
		begin
			slip_cnt_q <= slip_cnt_d;
		end
	end

	// read path: snapshot, read data and error flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lat_q <= `EPM_RST_CNT16;
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end
		else if (clk_en)
		begin
			lat_q <= lat_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// interrupt status and mask
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat_q <= `EPM_RST_IRQ;
			irq_mask_q <= `EPM_RST_IRQ;
		end
		else if (clk_en)
		begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
		end
	end

endmodule

// >>> inc/epm_defs.vh
// register offsets, field positions and reset values of the performance monitor counters
`ifndef EPM_DEFS_VH
`define EPM_DEFS_VH

// apb address width in bits (byte addresses)
`define EPM_ADDR_W 8

// register byte offsets, one aligned 32-bit word each
`define EPM_OFF_PAT_UPPER 8'h00
`define EPM_OFF_PAT_LOWER 8'h04
`define EPM_OFF_SLIP 8'h08
`define EPM_OFF_ZV_UPPER 8'h0C
`define EPM_OFF_ZV_LOWER 8'h10
`define EPM_OFF_IRQ_STATUS 8'h14
`define EPM_OFF_IRQ_MASK 8'h18

// byte fields of a 16-bit count
`define EPM_HI_MSB 15
`define EPM_HI_LSB 8
`define EPM_LO_MSB 7
`define EPM_LO_LSB 0

// interrupt status and mask bit positions: a counter has reached all ones
`define EPM_IRQ_PAT_SAT 0
`define EPM_IRQ_SLIP_SAT 1
`define EPM_IRQ_ZV_SAT 2
`define EPM_IRQ_W 3

// reset values
`define EPM_RST_CNT16 16'h0000
`define EPM_RST_CNT8 8'h00
`define EPM_RST_IRQ 3'h0

`endif

// >>> tb/epm_counters_properties.sv
// assertions on the ports of the performance monitor counters
`timescale 1ns/1ps
`include "epm_defs.vh"
module epm_chk
(
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`EPM_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire tx_slip_evt,
	input wire irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase and mapped word addresses
	wire acc = psel && penable;
	wire mapd = paddr[1:0] == 2'h0 && paddr <= 8'h18;
	sequence slip_rd;
		!tx_slip_evt ##1 (acc && !pwrite && paddr == `EPM_OFF_SLIP && clk_en && !tx_slip_evt);
	endsequence
	ready_follow_a: assert property (pready == clk_en) else $error("pready off");
	err_unmapped_a: assert property (acc && paddr > 8'h18 |-> pslverr) else $error("no err");
	err_mapped_a: assert property (acc && mapd |-> !pslverr) else $error("false err");
	byte_only_a: assert property (acc && paddr < 8'h14 |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	rdata_hold_a: assert property (psel && !penable && clk_en |=> ##1 $stable(prdata))
		else $error("read data moved");
	// the idle cycle must carry no slip either, else the next read is not zero
	slip_clear_a: assert property (slip_rd ##1 (!psel && !tx_slip_evt) ##1 (psel && !penable
		&& paddr == `EPM_OFF_SLIP && clk_en) |=> prdata == 32'h0) else $error("slip not cleared");
	unmapped_zero_a: assert property (psel && !penable && paddr > 8'h18 && clk_en
		|=> prdata == 32'h0) else $error("unmapped data");
	irq_off_a: assert property (acc && pwrite && pready && paddr == `EPM_OFF_IRQ_MASK
		&& pwdata[2:0] == 3'h0 |=> !irq) else $error("irq while masked");
	cover property (slip_rd);
	cover property (acc && paddr > 8'h18);
	cover property ($rose(irq));
endmodule
bind epm_counters epm_chk chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .tx_slip_evt(tx_slip_evt), .irq(irq));

// >>> tb/epm_counters_tb.sv
// self-checking bench for the performance monitor counters
`timescale 1ns/1ps
`include "epm_defs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module epm_counters_tb;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, clk_en = 1;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd;
	reg [2:0] ev = 3'h0;
	wire pready, pslverr, irq;
	wire [31:0] prdata;
	int n_mismatch = 0, n_checks = 0, i;
	epm_counters dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .pattern_error_evt(ev[0]),
		.tx_slip_evt(ev[1]), .zero_violation_evt(ev[2]), .irq(irq));
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	// one transfer; data and error are taken at the edge that sees pready
	task xfer(input [7:0] a, input w, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input [7:0] a, input [7:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK(rd, {24'h0, e})
	endtask
	// one event per cycle for n cycles
	task pulse(input int b, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			ev[b] <= 1'b1;
		end
		@(posedge pclk);
		ev[b] <= 1'b0;
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// cut a hang short after some 80k cycles
	initial
	begin
		#3200000;
		n_mismatch++;
		results;
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i <= 16; i += 4)
			rchk(i[7:0], 8'h00);
		pulse(0, 300);
		rchk(`EPM_OFF_PAT_UPPER, 8'h01);
		rchk(`EPM_OFF_PAT_LOWER, 8'h2C);
		rchk(`EPM_OFF_PAT_UPPER, 8'h00);
		rchk(`EPM_OFF_PAT_LOWER, 8'h00);
		// events between the halves are kept for the next pair
		pulse(0, 5);
		rchk(`EPM_OFF_PAT_UPPER, 8'h00);
		pulse(0, 3);
		rchk(`EPM_OFF_PAT_LOWER, 8'h05);
		rchk(`EPM_OFF_PAT_UPPER, 8'h00);
		rchk(`EPM_OFF_PAT_LOWER, 8'h03);
		// strobes while the clock enable is low are not counted
		clk_en <= 1'b0;
		pulse(0, 4);
		clk_en <= 1'b1;
		rchk(`EPM_OFF_PAT_UPPER, 8'h00);
		rchk(`EPM_OFF_PAT_LOWER, 8'h00);
		// a lower read alone clears nothing
		pulse(2, 4);
		rchk(`EPM_OFF_ZV_LOWER, 8'h04);
		rchk(`EPM_OFF_ZV_LOWER, 8'h04);
		rchk(`EPM_OFF_ZV_UPPER, 8'h00);
		rchk(`EPM_OFF_ZV_LOWER, 8'h04);
		rchk(`EPM_OFF_ZV_LOWER, 8'h00);
		pulse(1, 7);
		xfer(`EPM_OFF_SLIP, 1'b1, 32'hFF);
		rchk(`EPM_OFF_SLIP, 8'h07);
		rchk(`EPM_OFF_SLIP, 8'h00);
		// slip saturation raises the interrupt, then mask and clear it
		xfer(`EPM_OFF_IRQ_MASK, 1'b1, 32'h2);
		pulse(1, 260);
		`CHK(irq, 1'b1)
		rchk(`EPM_OFF_SLIP, 8'hFF);
		xfer(`EPM_OFF_IRQ_MASK, 1'b1, 32'h0);
		@(posedge pclk);
		`CHK(irq, 1'b0)
		xfer(`EPM_OFF_IRQ_STATUS, 1'b1, 32'h2);
		rchk(`EPM_OFF_IRQ_STATUS, 8'h00);
		pulse(2, 65540);
		rchk(`EPM_OFF_ZV_UPPER, 8'hFF);
		rchk(`EPM_OFF_ZV_LOWER, 8'hFF);
		rchk(`EPM_OFF_IRQ_STATUS, 8'h04);
		xfer(8'h1C, 1'b0, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		results;
	end
endmodule
